// ---- src/mac_addr_hash_pkg.sv ----
// Purpose: constants and types for the station address, group hash and
//          phy management register slice
// Assumes: 32-bit AHB-Lite register port, 200 MHz system clock
// Notes:   register byte address is four times the register index
package mac_addr_hash_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices (byte address = 4 * index)
  localparam int REG_IDX_W = 6;
  localparam logic [5:0] IDX_GROUP_CTRL = 6'h01;
  localparam logic [5:0] IDX_ADDR_HIGH = 6'h02;
  localparam logic [5:0] IDX_ADDR_LOW = 6'h03;
  localparam logic [5:0] IDX_HASH_UPPER = 6'h04;
  localparam logic [5:0] IDX_HASH_LOWER = 6'h05;
  localparam logic [5:0] IDX_MGMT_CTRL = 6'h06;
  localparam logic [5:0] IDX_MGMT_DATA = 6'h07;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] RST_ADDR_HIGH = 16'hffff;
  localparam logic [31:0] RST_ADDR_LOW = 32'h0fffffff;
  localparam logic [31:0] RST_HASH = 32'h00000000;
  localparam logic [15:0] RST_MGMT = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int GC_ACCEPT_ALL_BIT = 0;
  localparam int GC_LOADED_BIT = 1;
  localparam int MC_PENDING_BIT = 0;
  localparam int MC_WRITE_BIT = 1;
  localparam int MC_REG_LSB = 6;
  localparam int MC_PHY_LSB = 11;
  localparam int MC_FIELD_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // eeprom byte addresses
  localparam logic [7:0] EE_LOW_FIRST = 8'h01;
  localparam logic [7:0] EE_LOW_LAST = 8'h04;
  localparam logic [7:0] EE_HIGH_FIRST = 8'h05;
  localparam logic [7:0] EE_HIGH_LAST = 8'h06;

  ////////////////////////////////////////////////////////////////////////////
  // management frame layout and timing
  localparam int MGMT_FRAME_W = 64;
  localparam int MGMT_READ_HIZ_BIT = 46;
  localparam int MGMT_DATA_BIT = 48;
  localparam logic [31:0] MGMT_PREAMBLE = 32'hffffffff;
  localparam logic [1:0] MGMT_START = 2'h1;
  localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
  localparam logic [1:0] MGMT_OP_READ = 2'h2;
  localparam logic [1:0] MGMT_TA_WRITE = 2'h2;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MDC_PERIOD_NS = 400;
  localparam int MDC_HALF_CYCLES =
    (MDC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // hash
  localparam int HASH_IDX_W = 6;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic valid;
    logic wr;
    logic [REG_IDX_W-1:0] idx;
  } bus_req_t;

  typedef struct packed {
    logic mdc;
    logic dout;
    logic oe_n;
  } mgmt_pins_t;

  typedef enum logic {MG_IDLE, MG_SHIFT} mgmt_state_t;

endpackage

// ---- src/group_hash_crc.sv ----
// Purpose: crc over a destination address, bytes in wire order
// Assumes: first wire byte in the top bits, each byte sent lsb first
// Notes:   purely combinational; caller registers the result
`timescale 1ns/1ps
module group_hash_crc import mac_addr_hash_pkg::*; #(
  parameter int DATA_W = 48
) (
  // address in
  input wire logic [DATA_W-1:0] data_i,
  // crc out
  output logic [31:0] crc_o
);

  logic [31:0] crc;
  logic fb;

  // crc runs in wire order: bytes first to last, bits lsb first
  always_comb begin
    crc = CRC_INIT;
    fb = 1'b0;
    for (int b = DATA_W / 8 - 1; b >= 0; b--) begin
      for (int k = 0; k < 8; k++) begin
        fb = crc[31] ^ data_i[b*8+k];
        crc = {crc[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
      end
    end
    crc_o = crc;
  end

endmodule // group_hash_crc

// ---- src/mac_addr_hash_phy_mgmt_regs.sv ----
// Purpose: station address, multicast hash table and phy management
//          registers behind an AHB-Lite slave
// Assumes: single word transfers, zero wait states, one clock
// Notes:   hsize is not checked; every access is handled as a word
`timescale 1ns/1ps
module mac_addr_hash_phy_mgmt_regs import mac_addr_hash_pkg::*; #(
  parameter int MDC_HALF = MDC_HALF_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // eeprom loader bytes
  input wire logic EE_BYTE_VALID_I,
  input wire logic [7:0] EE_BYTE_ADDR_I,
  input wire logic [7:0] EE_BYTE_DATA_I,
  input wire logic EE_LOAD_DONE_I,
  // station address, first wire byte in bits 47:40
  output logic [47:0] STATION_ADDR_O,
  // group filter
  input wire logic DA_VALID_I,
  input wire logic [47:0] DA_I,
  output logic GRP_VALID_O,
  output logic GRP_MULTICAST_O,
  output logic GRP_ACCEPT_O,
  // phy management pins
  output logic MDC_O,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  bus_req_t req_q, req_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] addr_high_q, addr_high_d;
  logic [31:0] addr_low_q, addr_low_d;
  logic [31:0] hash_up_q, hash_up_d;
  logic [31:0] hash_lo_q, hash_lo_d;
  logic accept_all_q, accept_all_d;
  logic loaded_q, loaded_d;
  logic [15:0] mctrl_q, mctrl_d;
  logic [15:0] mdata_q, mdata_d;
  mgmt_state_t st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [5:0] bit_q, bit_d;
  logic [MGMT_FRAME_W-1:0] frame_q, frame_d;
  logic [15:0] rd_shift_q, rd_shift_d;
  mgmt_pins_t pins_q, pins_d;
  logic grp_valid_q, grp_valid_d;
  logic grp_mc_q, grp_mc_d;
  logic grp_acc_q, grp_acc_d;

  logic [31:0] crc;
  logic [HASH_IDX_W-1:0] hidx;
  logic hash_bit;
  logic is_read;
  logic [1:0] op;
  logic [15:0] wdat;
  logic [7:0] div_top;

  assign div_top = 8'(MDC_HALF - 1);

  ////////////////////////////////////////////////////////////////////////////
  // hash index from the crc of the destination address

  group_hash_crc #(
    .DATA_W(48)
  ) u_crc (
    .data_i(DA_I),
    .crc_o(crc)
  );

  assign hidx = crc[31:26];
  // top index bit picks the register, low five pick the bit
  assign hash_bit = hidx[5] ? hash_up_q[hidx[4:0]] :
                    hash_lo_q[hidx[4:0]];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    req_d = req_q;
    rdata_d = rdata_q;
    addr_high_d = addr_high_q;
    addr_low_d = addr_low_q;
    hash_up_d = hash_up_q;
    hash_lo_d = hash_lo_q;
    accept_all_d = accept_all_q;
    loaded_d = loaded_q | EE_LOAD_DONE_I;
    mctrl_d = mctrl_q;
    mdata_d = mdata_q;
    st_d = st_q;
    div_d = div_q;
    bit_d = bit_q;
    frame_d = frame_q;
    rd_shift_d = rd_shift_q;
    pins_d = pins_q;
    is_read = ~mctrl_q[MC_WRITE_BIT];
    op = MGMT_OP_READ;
    wdat = HWDATA_I[15:0];

    // group filter result, one cycle after the address
    grp_valid_d = DA_VALID_I;
    grp_mc_d = DA_VALID_I & DA_I[40];
    grp_acc_d = DA_VALID_I & DA_I[40] &
                (accept_all_q | hash_bit);

    // eeprom bytes land in wire order, host write below may override
    if (EE_BYTE_VALID_I) begin
      if (EE_BYTE_ADDR_I >= EE_LOW_FIRST &&
          EE_BYTE_ADDR_I <= EE_LOW_LAST) begin
        case (EE_BYTE_ADDR_I[1:0])
          2'h1: addr_low_d[7:0] = EE_BYTE_DATA_I;
          2'h2: addr_low_d[15:8] = EE_BYTE_DATA_I;
          2'h3: addr_low_d[23:16] = EE_BYTE_DATA_I;
          default: addr_low_d[31:24] = EE_BYTE_DATA_I;
        endcase
      end else if (EE_BYTE_ADDR_I == EE_HIGH_FIRST) begin
        addr_high_d[7:0] = EE_BYTE_DATA_I;
      end else if (EE_BYTE_ADDR_I == EE_HIGH_LAST) begin
        addr_high_d[15:8] = EE_BYTE_DATA_I;
      end
    end

    // management frame engine
    case (st_q)
      MG_IDLE: begin
        div_d = 8'h00;
        pins_d = '{mdc: 1'b0, dout: 1'b1, oe_n: 1'b1};
      end
      MG_SHIFT: begin
        if (div_q == div_top) begin
          div_d = 8'h00;
          pins_d.mdc = ~pins_q.mdc;
          if (!pins_q.mdc) begin
            // rising edge: phy data is stable, sample it
            if (is_read && int'(bit_q) >= MGMT_DATA_BIT) begin
              rd_shift_d = {rd_shift_q[14:0], MDIO_I};
            end
          end else if (bit_q == 6'(MGMT_FRAME_W - 1)) begin
            st_d = MG_IDLE;
            pins_d.oe_n = 1'b1;
            if (is_read) begin
              mdata_d = rd_shift_q;
            end
            mctrl_d[MC_PENDING_BIT] = 1'b0;
          end else begin
            bit_d = bit_q + 6'h01;
            frame_d = {frame_q[MGMT_FRAME_W-2:0], 1'b0};
            pins_d.dout = frame_q[MGMT_FRAME_W-2];
            // read frames release the line from turnaround on
            pins_d.oe_n = is_read &&
                          int'(bit_q) + 1 >= MGMT_READ_HIZ_BIT;
          end
        end else begin
          div_d = div_q + 8'h01;
        end
      end
      default: begin
        st_d = MG_IDLE;
      end
    endcase

    // bus data phase: apply a write
    if (req_q.valid && req_q.wr) begin
      case (req_q.idx)
        IDX_GROUP_CTRL: accept_all_d = HWDATA_I[GC_ACCEPT_ALL_BIT];
        IDX_ADDR_HIGH: addr_high_d = wdat;
        IDX_ADDR_LOW: addr_low_d = HWDATA_I;
        IDX_HASH_UPPER: hash_up_d = HWDATA_I;
        IDX_HASH_LOWER: hash_lo_d = HWDATA_I;
        IDX_MGMT_DATA: begin
          // writes while busy are dropped to protect the frame
          if (!mctrl_q[MC_PENDING_BIT]) begin
            mdata_d = wdat;
          end
        end
        IDX_MGMT_CTRL: begin
          if (!mctrl_q[MC_PENDING_BIT]) begin
            mctrl_d = wdat & 16'hffc3;
            // an access starts only on a written 1 in bit 0
            if (wdat[MC_PENDING_BIT]) begin
              op = wdat[MC_WRITE_BIT] ? MGMT_OP_WRITE :
                   MGMT_OP_READ;
              frame_d = {MGMT_PREAMBLE, MGMT_START, op,
                         wdat[MC_PHY_LSB +: MC_FIELD_W],
                         wdat[MC_REG_LSB +: MC_FIELD_W],
                         wdat[MC_WRITE_BIT] ? MGMT_TA_WRITE : 2'h3,
                         wdat[MC_WRITE_BIT] ? mdata_q : 16'hffff};
              st_d = MG_SHIFT;
              bit_d = 6'h00;
              div_d = 8'h00;
              rd_shift_d = 16'h0000;
              pins_d = '{mdc: 1'b0, dout: 1'b1, oe_n: 1'b0};
            end
          end
        end
        default: begin
        end
      endcase
    end

    // bus address phase; read data reflects this cycle's updates
    req_d.valid = HSEL_I & HTRANS_I[1] & HREADY_I;
    req_d.wr = HWRITE_I;
    req_d.idx = HADDR_I[REG_IDX_W+1:2];
    if (req_d.valid && !HWRITE_I) begin
      case (req_d.idx)
        IDX_GROUP_CTRL: rdata_d = {30'h0, loaded_d, accept_all_d};
        IDX_ADDR_HIGH: rdata_d = {16'h0000, addr_high_d};
        IDX_ADDR_LOW: rdata_d = addr_low_d;
        IDX_HASH_UPPER: rdata_d = hash_up_d;
        IDX_HASH_LOWER: rdata_d = hash_lo_d;
        IDX_MGMT_CTRL: rdata_d = {16'h0000, mctrl_d};
        IDX_MGMT_DATA: rdata_d = {16'h0000, mdata_d};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      req_q <= '0;
      rdata_q <= 32'h00000000;
      addr_high_q <= RST_ADDR_HIGH;
      addr_low_q <= RST_ADDR_LOW;
      hash_up_q <= RST_HASH;
      hash_lo_q <= RST_HASH;
      accept_all_q <= 1'b0;
      loaded_q <= 1'b0;
      mctrl_q <= RST_MGMT;
      mdata_q <= RST_MGMT;
      st_q <= MG_IDLE;
      div_q <= 8'h00;
      bit_q <= 6'h00;
      frame_q <= '0;
      rd_shift_q <= 16'h0000;
      pins_q <= '{mdc: 1'b0, dout: 1'b1, oe_n: 1'b1};
      grp_valid_q <= 1'b0;
      grp_mc_q <= 1'b0;
      grp_acc_q <= 1'b0;
    end else begin
      req_q <= req_d;
      rdata_q <= rdata_d;
      addr_high_q <= addr_high_d;
      addr_low_q <= addr_low_d;
      hash_up_q <= hash_up_d;
      hash_lo_q <= hash_lo_d;
      accept_all_q <= accept_all_d;
      loaded_q <= loaded_d;
      mctrl_q <= mctrl_d;
      mdata_q <= mdata_d;
      st_q <= st_d;
      div_q <= div_d;
      bit_q <= bit_d;
      frame_q <= frame_d;
      rd_shift_q <= rd_shift_d;
      pins_q <= pins_d;
      grp_valid_q <= grp_valid_d;
      grp_mc_q <= grp_mc_d;
      grp_acc_q <= grp_acc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign HRDATA_O = rdata_q;
  // zero wait states: every access finishes in its first data cycle
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  // first wire byte is the low register's low byte
  assign STATION_ADDR_O = {addr_low_q[7:0], addr_low_q[15:8],
                           addr_low_q[23:16], addr_low_q[31:24],
                           addr_high_q[7:0],
                           addr_high_q[15:8]};
  assign GRP_VALID_O = grp_valid_q;
  assign GRP_MULTICAST_O = grp_mc_q;
  assign GRP_ACCEPT_O = grp_acc_q;
  assign MDC_O = pins_q.mdc;
  assign MDIO_O = pins_q.dout;
  assign MDIO_OE_N_O = pins_q.oe_n;

endmodule // mac_addr_hash_phy_mgmt_regs

// ---- verif/mac_regs_asserts.sv ----
// Purpose: port assertions for the address, hash and mgmt registers
// Assumes: one clock, synchronous active-low reset
// Notes:   helper logic follows the management frame from its start
`timescale 1ns/1ps
module mac_regs_chk import mac_addr_hash_pkg::*; #(
  parameter int MDC_HALF = 40
) (
  // clock, reset and bus
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  // eeprom and address
  input wire logic EE_BYTE_VALID_I,
  input wire logic [7:0] EE_BYTE_ADDR_I,
  input wire logic [7:0] EE_BYTE_DATA_I,
  input wire logic [47:0] STATION_ADDR_O,
  // filter and management
  input wire logic DA_VALID_I,
  input wire logic [47:0] DA_I,
  input wire logic GRP_VALID_O,
  input wire logic GRP_MULTICAST_O,
  input wire logic GRP_ACCEPT_O,
  input wire logic MDC_O,
  input wire logic MDIO_O,
  input wire logic MDIO_OE_N_O
);
  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] wr_idx_q, wr_idx_d;
  logic active_q, active_d;
  logic [6:0] rises_q, rises_d;
  logic [7:0] high_q, high_d;
  logic mdc_q;
  // index 0 is unmapped, so it doubles as "no write in data phase"
  always_comb begin
    wr_idx_d = 6'h00;
    if (HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I) begin
      wr_idx_d = HADDR_I[7:2];
    end
    active_d = active_q;
    rises_d = rises_q;
    if (wr_idx_q == IDX_MGMT_CTRL && HWDATA_I[0]) begin
      active_d = 1'b1;
    end
    if (MDC_O && !mdc_q) begin
      rises_d = rises_q + 7'h01;
    end
    if (!MDC_O && mdc_q && rises_q == 7'h40) begin
      active_d = 1'b0;
      rises_d = 7'h00;
    end
    high_d = MDC_O ? high_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      wr_idx_q <= 6'h00;
      active_q <= 1'b0;
      rises_q <= 7'h00;
      high_q <= 8'h00;
      mdc_q <= 1'b0;
    end else begin
      wr_idx_q <= wr_idx_d;
      active_q <= active_d;
      rises_q <= rises_d;
      high_q <= high_d;
      mdc_q <= MDC_O;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence mg_start;
    wr_idx_q == IDX_MGMT_CTRL && HWDATA_I[0] && !active_q;
  endsequence
  sequence first_bit;
    ##[1:200] ($rose(MDC_O) && !MDIO_OE_N_O && MDIO_O);
  endsequence
  chk_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
    else $error("slave stalled or answered with error");
  chk_filter_pulse: assert property (GRP_VALID_O == $past(DA_VALID_I))
    else $error("filter result pulse misplaced");
  chk_group_bit: assert property (DA_VALID_I |=>
    GRP_MULTICAST_O == $past(DA_I[40]) && (!GRP_ACCEPT_O || GRP_MULTICAST_O))
    else $error("group flag or accept wrong");
  chk_low_write: assert property (wr_idx_q == IDX_ADDR_LOW |=>
    STATION_ADDR_O[47:16] == {$past(HWDATA_I[7:0]), $past(HWDATA_I[15:8]),
    $past(HWDATA_I[23:16]), $past(HWDATA_I[31:24])})
    else $error("low address write not in wire order");
  chk_ee_byte: assert property (EE_BYTE_VALID_I &&
    EE_BYTE_ADDR_I inside {[8'h01:8'h06]} && wr_idx_q != IDX_ADDR_LOW &&
    wr_idx_q != IDX_ADDR_HIGH |=> STATION_ADDR_O[8*(6-$past(EE_BYTE_ADDR_I))+:8]
    == $past(EE_BYTE_DATA_I))
    else $error("eeprom byte landed in wrong place");
  chk_access_start: assert property ($rose(MDC_O) |-> active_q)
    else $error("management clock ran without a start");
  chk_frame_start: assert property (mg_start |-> first_bit)
    else $error("frame did not start with driven preamble");
  chk_mdc_half: assert property ($fell(MDC_O) |-> high_q == MDC_HALF)
    else $error("management clock high time wrong");
  chk_read_release: assert property ($rose(MDIO_OE_N_O) |->
    rises_q == 7'h2e || rises_q == 7'h40)
    else $error("data line released at wrong bit");
endmodule // mac_regs_chk

bind mac_addr_hash_phy_mgmt_regs mac_regs_chk #(.MDC_HALF(MDC_HALF))
  i_mac_regs_chk (.*);

// ---- verif/phy_mgmt_model.sv ----
// Purpose: behavioural phy on the management pins
// Assumes: mdc idles low; line has a pull-up
// Notes:   records the last 64-bit frame as seen on the wire
`timescale 1ns/1ps
module phy_mgmt_model import mac_addr_hash_pkg::*; #(
  parameter logic [15:0] READ_VALUE = 16'h3c5a
) (
  // wire side
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  // observation
  output logic [63:0] frame_o,
  output logic [7:0] frames_o
);
  logic [63:0] sr;
  logic [6:0] cnt;
  logic rd;
  initial begin
    sr = 64'h0;
    cnt = 7'h00;
    rd = 1'b0;
    mdio_o = 1'b1;
    frame_o = 64'h0;
    frames_o = 8'h00;
  end
  always @(posedge mdc_i) begin
    sr <= {sr[62:0], mdio_i};
    if (cnt == 7'h23) begin
      rd <= {sr[0], mdio_i} == MGMT_OP_READ;
    end
    cnt <= (cnt == 7'h3f) ? 7'h00 : cnt + 7'h01;
    if (cnt == 7'h3f) begin
      frame_o <= {sr[62:0], mdio_i};
      frames_o <= frames_o + 8'h01;
    end
  end
  // change on the fall so the level is stable around every rise
  always @(negedge mdc_i) begin
    mdio_o <= (rd && cnt >= 7'h30) ? READ_VALUE[7'h3f - cnt] : 1'b1;
  end
endmodule // phy_mgmt_model

// ---- verif/mac_addr_hash_phy_mgmt_regs_tb.sv ----
// Purpose: self-checking bench for the address, hash and mgmt registers
// Assumes: one ahb-lite master, phy model on the management pins
// Notes:   MDC_HALF cut to 2 so one access takes about 257 cycles
`timescale 1ns/1ps
module mac_addr_hash_phy_mgmt_regs_tb import mac_addr_hash_pkg::*;;
  localparam logic [15:0] READ_VAL = 16'h3c5a;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, ee_v = 0, ee_done = 0;
  logic da_v = 0, hready, hresp, g_v, g_m, g_a, mdc, mdo, moe_n, phy_mdio;
  logic mdio;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [7:0] ee_a = 0, ee_d = 0, frames;
  logic [47:0] da = 0, station;
  logic [63:0] frame;
  int bad_count = 0, num_checks = 0, cyc = 0;
  assign mdio = moe_n ? phy_mdio : mdo;
  mac_addr_hash_phy_mgmt_regs #(.MDC_HALF(2)) i_mac_addr_hash_phy_mgmt_regs (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .EE_BYTE_VALID_I(ee_v), .EE_BYTE_ADDR_I(ee_a),
    .EE_BYTE_DATA_I(ee_d), .EE_LOAD_DONE_I(ee_done), .STATION_ADDR_O(station),
    .DA_VALID_I(da_v), .DA_I(da), .GRP_VALID_O(g_v), .GRP_MULTICAST_O(g_m),
    .GRP_ACCEPT_O(g_a), .MDC_O(mdc), .MDIO_I(mdio), .MDIO_O(mdo),
    .MDIO_OE_N_O(moe_n));
  phy_mgmt_model #(.READ_VALUE(READ_VAL)) i_phy_mgmt_model (.mdc_i(mdc),
    .mdio_i(mdio), .mdio_o(phy_mdio), .frame_o(frame), .frames_o(frames));
  initial begin
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rd_chk(input string n, input logic [5:0] idx,
                        input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    check(n, x, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk("addr_low", IDX_ADDR_LOW, 32'h0fffffff);
    rd_chk("hash_up", IDX_HASH_UPPER, 32'h0);
    rd_chk("hash_lo", IDX_HASH_LOWER, 32'h0);
    rd_chk("mgmt_ctrl", IDX_MGMT_CTRL, 32'h0);
    rd_chk("unmapped", 6'h20, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_addr();
    for (int i = 1; i <= 6; i++) begin
      @(posedge clk);
      ee_v <= 1'b1;
      ee_a <= i[7:0];
      ee_d <= 8'h11 * i[7:0];
    end
    @(posedge clk);
    ee_v <= 1'b0;
    ee_done <= 1'b1;
    rd_chk("ee_low", IDX_ADDR_LOW, 32'h44332211);
    rd_chk("ee_high", IDX_ADDR_HIGH, 32'h00006655);
    rd_chk("loaded", IDX_GROUP_CTRL, 32'h00000002);
    check("ee_station", station, 48'h112233445566);
    wr(IDX_ADDR_LOW, 32'h78563412);
    wr(IDX_ADDR_HIGH, 32'h0000bc9a);
    rd_chk("host_low", IDX_ADDR_LOW, 32'h78563412);
    check("host_station", station, 48'h123456789abc);
    $display("test address done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      c = {c[30:0], 1'b0} ^
          ((c[31] ^ a[40 - 8 * (i / 8) + i % 8]) ? CRC_POLY : 32'h0);
    end
    return c[31:26];
  endfunction
  task automatic probe(input logic [47:0] a, input logic e_m, e_a);
    @(posedge clk);
    da <= a;
    da_v <= 1'b1;
    @(posedge clk);
    da_v <= 1'b0;
    @(posedge clk);
    check("grp_valid", g_v, 1'b1);
    check("grp_multi", g_m, e_m);
    check("grp_accept", g_a, e_a);
  endtask
  task automatic t_filter();
    logic [47:0] a;
    logic [5:0] x;
    logic [31:0] m;
    int n;
    n = 0;
    for (int k = 0; k < 400 && n < 6; k++) begin
      a = {32'h01005e00, k[15:0]};
      x = hidx(a);
      m = 32'h1 << x[4:0];
      if (k < 3 || x == 6'h00 || x == 6'h3f || x == 6'h1f || x == 6'h20) begin
        n++;
        wr(IDX_HASH_UPPER, x[5] ? m : 32'h0);
        wr(IDX_HASH_LOWER, x[5] ? 32'h0 : m);
        probe(a, 1'b1, 1'b1);
        wr(IDX_HASH_UPPER, x[5] ? ~m : 32'hffffffff);
        wr(IDX_HASH_LOWER, x[5] ? 32'hffffffff : ~m);
        probe(a, 1'b1, 1'b0);
      end
    end
    wr(IDX_GROUP_CTRL, 32'h1);
    probe(a, 1'b1, 1'b1);
    probe({8'h00, a[39:0]}, 1'b0, 1'b0);
    wr(IDX_GROUP_CTRL, 32'h0);
    rd_chk("hash_keep", IDX_HASH_LOWER, x[5] ? 32'hffffffff : ~m);
    $display("test filter done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic poll_idle();
    logic [31:0] x;
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_MGMT_CTRL, 32'h0, x);
      n++;
    end while (x[0] !== 1'b0 && n < 200);
    check("pending_clear", x[0], 1'b0);
  endtask
  task automatic t_mgmt();
    poll_idle();
    wr(IDX_MGMT_DATA, 32'h0000a5c3);
    wr(IDX_MGMT_CTRL, 32'h00000942);
    rd_chk("no_start", IDX_MGMT_CTRL, 32'h00000942);
    wr(IDX_MGMT_CTRL, 32'h00000943);
    rd_chk("busy", IDX_MGMT_CTRL, 32'h00000943);
    // this write is meant to be dropped while the access runs
    wr(IDX_MGMT_DATA, 32'h00001111);
    rd_chk("data_kept", IDX_MGMT_DATA, 32'h0000a5c3);
    poll_idle();
    check("wr_frame", frame, {32'hffffffff, 4'h5, 5'h01, 5'h05, 2'h2,
      16'ha5c3});
    wr(IDX_MGMT_CTRL, 32'h000008c1);
    poll_idle();
    rd_chk("rd_data", IDX_MGMT_DATA, {16'h0, READ_VAL});
    rd_chk("ctrl_done", IDX_MGMT_CTRL, 32'h000008c0);
    check("rd_frame", frame, {32'hffffffff, 4'h6, 5'h01, 5'h03, 2'h3,
      READ_VAL});
    check("frame_count", frames, 8'h02);
    $display("test management done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_addr();
    t_filter();
    t_mgmt();
    give_verdict();
  end
endmodule // mac_addr_hash_phy_mgmt_regs_tb
